// ---- design/ptc_pkg.sv ----
package ptc_pkg;
   // Register indices; each register is one word on the plain register port.
   localparam logic [4:0] ADDR_COMMAND      = 5'h00;
   localparam logic [4:0] ADDR_SECONDS      = 5'h01;
   localparam logic [4:0] ADDR_NANOSECONDS  = 5'h02;
   localparam logic [4:0] ADDR_SUBNANO      = 5'h03;
   localparam logic [4:0] ADDR_RATE_TRIM    = 5'h04;
   localparam logic [4:0] ADDR_STEP_AMOUNT  = 5'h05;
   localparam logic [4:0] ADDR_TEMP_TRIM    = 5'h06;
   localparam logic [4:0] ADDR_TEMP_CYCLES  = 5'h07;
   localparam logic [4:0] ADDR_GENERAL_CFG  = 5'h08;
   localparam logic [4:0] ADDR_EVENT_STATUS = 5'h09;
   localparam logic [4:0] ADDR_EVENT_ENABLE = 5'h0A;
   // Per channel block: base plus channel times stride.
   localparam logic [4:0] ADDR_CH_BASE      = 5'h10;
   localparam int         CH_STRIDE         = 4;
   localparam logic [1:0] CH_TGT_SEC        = 2'h0;
   localparam logic [1:0] CH_TGT_NS         = 2'h1;
   localparam logic [1:0] CH_INT_SEC        = 2'h2;
   localparam logic [1:0] CH_INT_NS         = 2'h3;

   // Command register bits.
   localparam int CMD_SNAPSHOT    = 0;
   localparam int CMD_LOAD        = 1;
   localparam int CMD_STEP_SEC    = 2;
   localparam int CMD_STEP_NS     = 3;
   localparam int CMD_TEMP_RATE   = 4;
   localparam int CMD_TGT_SNAP    = 5;
   // Direction bit of trim and step registers; 1 means speed-up or add.
   localparam int DIR_BIT         = 31;
   localparam int TRIM_VALUE_W    = 30;
   localparam int STEP_VALUE_W    = 30;

   localparam logic [29:0] NS_PER_SEC  = 30'd1_000_000_000;
   localparam logic [29:0] NS_NOMINAL  = 30'd10;
   localparam logic [29:0] NS_SLOW     = 30'd9;
   localparam logic [29:0] NS_FAST     = 30'd11;
   localparam logic [31:0] RESET_ZERO  = 32'h0000_0000;
endpackage

// ---- design/ptc_time_clock.sv ----
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
// What this block does
// - Time is a 32-bit seconds count plus a 30-bit nanoseconds count.
// - Each reference cycle normally adds 10 to nanoseconds.
// - At or above 10^9 nanoseconds, subtract 10^9 and bump seconds.
// - Snapshot command copies seconds, nanoseconds, sub-nanoseconds to readable holders.
// - Each cycle the trim value is added to a 32-bit sub-nanosecond accumulator.
// - On accumulator wrap add 9 or 11 instead of 10, per trim direction.
// - Software writes time registers then sets load; the time is replaced.
// - Seconds step adds or subtracts the step amount; nanoseconds untouched.
// - A nanoseconds wrap alongside a seconds step applies both to seconds.
// - Nanoseconds step adds the amount instead of the normal increment.
// - Nanoseconds step keeps the accumulator; a coincident wrap is lost.
// - Temporary rate runs for set cycles, then self-clears to normal trim.
// - Two compare channels each compare time against their own target.
// - A target updates only after both halves are written, either order.
// - Target snapshot copies both channel targets to readable registers.
// - Time at or past a target sets that channel's event flag.
// - With reload select 1 the target is loaded from the interval.
// - With reload select 0 the interval is added, nanoseconds wrap at 10^9.
// - An interval updates only after both halves are written, either order.
// - A load to at or past a target raises that channel's event.
// - Enabled event flags are ORed into one summary event bit.
module ptc_time_clock
   import ptc_pkg::*;
#(
   parameter int CHANNELS = 2
)
(
   // Clock and reset.
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // Register port.
   input  wire logic [4:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic      [31:0] reg_rdata,
   // Time and events.
   output logic      [31:0] time_seconds,
   output logic      [29:0] time_nanoseconds,
   output logic [CHANNELS-1:0] time_event_flags,
   output logic             time_summary_event
);
   import ptc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Register writes and command decode.

   logic [31:0] time_seconds_reg;
   logic [29:0] time_nanoseconds_reg;
   logic [31:0] time_subnano_reg;
   logic [31:0] rate_trim_reg;
   logic [31:0] step_amount_reg;
   logic [31:0] temp_trim_reg;
   logic [31:0] temp_cycles_reg;
   logic [CHANNELS-1:0] reload_select;
   logic [CHANNELS-1:0] event_enable;
   logic [31:0] subnano;
   logic        temp_active;
   logic [31:0] temp_left;

   // Command bits are pulses: each acts only in the cycle of its write, and nothing
   // is stored, so writing a command again simply repeats it.
   wire cmd_wr = reg_write && reg_addr == ADDR_COMMAND;

   wire do_snap     = cmd_wr && reg_wdata[CMD_SNAPSHOT];
   wire do_load     = cmd_wr && reg_wdata[CMD_LOAD];
   wire do_step_sec = cmd_wr && reg_wdata[CMD_STEP_SEC];
   wire do_step_ns  = cmd_wr && reg_wdata[CMD_STEP_NS];
   wire do_temp     = cmd_wr && reg_wdata[CMD_TEMP_RATE];
   wire do_tgt_snap = cmd_wr && reg_wdata[CMD_TGT_SNAP];

   // Configuration registers; channel registers are decoded in the channel section.
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         rate_trim_reg   <= RESET_ZERO;
         step_amount_reg <= RESET_ZERO;
         temp_trim_reg   <= RESET_ZERO;
         temp_cycles_reg <= RESET_ZERO;
         reload_select   <= '0;
         event_enable    <= '0;
      end
      else if (reg_write)
      begin
         unique case (reg_addr)
            ADDR_RATE_TRIM:    rate_trim_reg   <= reg_wdata;
            ADDR_STEP_AMOUNT:  step_amount_reg <= reg_wdata;
            ADDR_TEMP_TRIM:    temp_trim_reg   <= reg_wdata;
            ADDR_TEMP_CYCLES:  temp_cycles_reg <= reg_wdata;
            ADDR_GENERAL_CFG:  reload_select   <= reg_wdata[CHANNELS-1:0];
            ADDR_EVENT_ENABLE: event_enable    <= reg_wdata[CHANNELS-1:0];
            default:           ;
         endcase
      end
   end

   // The time holders serve both as load source and snapshot destination.
   // A snapshot taken between the time writes and the load replaces the load
   // source, so software must finish a load before asking for a snapshot.
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         time_seconds_reg     <= RESET_ZERO;
         time_nanoseconds_reg <= '0;
         time_subnano_reg     <= RESET_ZERO;
      end
      else if (do_snap)
      begin
         time_seconds_reg     <= time_seconds;
         time_nanoseconds_reg <= time_nanoseconds;
         time_subnano_reg     <= subnano;
      end
      else if (reg_write && reg_addr == ADDR_SECONDS)
         time_seconds_reg <= reg_wdata;
      else if (reg_write && reg_addr == ADDR_NANOSECONDS)
         time_nanoseconds_reg <= reg_wdata[29:0];
      else if (reg_write && reg_addr == ADDR_SUBNANO)
         time_subnano_reg <= reg_wdata;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Time counter.

   // Temporary rate overrides the normal trim while its duration runs.
   wire [31:0] trim_src  = temp_active ? temp_trim_reg : rate_trim_reg;
   // Only the value field feeds the accumulator; the direction bit merely picks
   // 9 or 11 on a carry, so a trim never moves the accumulator backwards.
   wire [32:0] sub_sum   = {1'b0, subnano} + {3'b000, trim_src[TRIM_VALUE_W-1:0]};
   wire        sub_wrap  = sub_sum[32];
   wire [29:0] ns_incr   = !sub_wrap ? NS_NOMINAL
                         : (trim_src[DIR_BIT] ? NS_FAST : NS_SLOW);
   // A nanoseconds step replaces the normal increment, losing any wrap.
   wire [29:0] ns_add    = do_step_ns ? step_amount_reg[STEP_VALUE_W-1:0]
                         : ns_incr;

   // One subtraction of 10^9 covers every increment and any step below 10^9;
   // a larger step amount would leave the count out of range, a limit for the user.
   wire [30:0] ns_sum    = {1'b0, time_nanoseconds} + {1'b0, ns_add};
   wire        ns_wrap   = ns_sum >= {1'b0, NS_PER_SEC};
   wire [30:0] ns_next   = ns_wrap ? ns_sum - {1'b0, NS_PER_SEC} : ns_sum;

   // Seconds step: bit 31 high adds, low subtracts; a wrap carry comes on top.
   wire [31:0] sec_delta = !do_step_sec ? 32'h0000_0000
                         : (step_amount_reg[DIR_BIT] ? {2'b00, step_amount_reg[29:0]}
                                                     : -{2'b00, step_amount_reg[29:0]});

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         time_seconds     <= RESET_ZERO;
         time_nanoseconds <= '0;
         subnano          <= RESET_ZERO;
      end
      else if (do_load)
      begin
         time_seconds     <= time_seconds_reg;
         time_nanoseconds <= time_nanoseconds_reg;
         subnano          <= time_subnano_reg;
      end
      else
      begin
         time_nanoseconds <= ns_next[29:0];
         time_seconds     <= time_seconds + sec_delta + {31'd0, ns_wrap};
         if (!do_step_ns)
            subnano <= sub_sum[31:0];
      end
   end

   // A zero duration leaves the normal trim in charge; a new temporary rate
   // command restarts the count from the programmed duration.
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         temp_active <= 1'b0;
         temp_left   <= RESET_ZERO;
      end
      else if (do_temp)
      begin
         temp_active <= temp_cycles_reg != 32'h0000_0000;
         temp_left   <= temp_cycles_reg;
      end
      else if (temp_active)
      begin
         temp_left <= temp_left - 32'h0000_0001;
         if (temp_left == 32'h0000_0001)
            temp_active <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Compare channels.

   logic [31:0] tgt_sec   [CHANNELS];
   logic [29:0] tgt_ns    [CHANNELS];
   logic [31:0] snap_sec  [CHANNELS];
   logic [29:0] snap_ns   [CHANNELS];
   logic [31:0] int_sec   [CHANNELS];
   logic [29:0] int_ns    [CHANNELS];
   // Each channel drives only its own bit of the flag vector, through its local flag.
   logic [CHANNELS-1:0] event_flag;

   // Status writes clear flags where a one is written; a new event wins.
   wire status_wr = reg_write && reg_addr == ADDR_EVENT_STATUS;

   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch++)
      begin : g_ch
         localparam logic [4:0] BASE = ADDR_CH_BASE + 5'(ch * CH_STRIDE);
         logic [31:0] pend_tsec;
         logic [29:0] pend_tns;
         logic [1:0]  pend_t;
         logic [31:0] pend_isec;
         logic [29:0] pend_ins;
         logic [1:0]  pend_i;
         logic        flag;

         // A half written twice before its partner replaces the pending value; the
         // pair commits, whole, on whichever half arrives second.
         wire in_blk = reg_write && reg_addr[4:2] == BASE[4:2];
         wire w_tsec = in_blk && reg_addr[1:0] == CH_TGT_SEC;
         wire w_tns  = in_blk && reg_addr[1:0] == CH_TGT_NS;
         wire w_isec = in_blk && reg_addr[1:0] == CH_INT_SEC;
         wire w_ins  = in_blk && reg_addr[1:0] == CH_INT_NS;
         wire t_done = (pend_t | {w_tns, w_tsec}) == 2'b11;
         wire i_done = (pend_i | {w_ins, w_isec}) == 2'b11;

         // Compare against the running time; a loaded time runs from the next edge,
         // so a load to or past the target raises the event one edge later.
         wire hit = {time_seconds, time_nanoseconds} >= {tgt_sec[ch], tgt_ns[ch]};
         wire [30:0] add_ns = {1'b0, tgt_ns[ch]} + {1'b0, int_ns[ch]};
         wire        add_c  = add_ns >= {1'b0, NS_PER_SEC};

         always_ff @(posedge core_clk)
         begin
            if (!rst_n)
            begin
               pend_t <= 2'b00;
               pend_i <= 2'b00;
               pend_tsec <= RESET_ZERO;
               pend_tns  <= '0;
               pend_isec <= RESET_ZERO;
               pend_ins  <= '0;
            end
            else
            begin
               if (w_tsec) pend_tsec <= reg_wdata;
               if (w_tns)  pend_tns  <= reg_wdata[29:0];
               if (w_isec) pend_isec <= reg_wdata;
               if (w_ins)  pend_ins  <= reg_wdata[29:0];
               pend_t <= t_done ? 2'b00 : (pend_t | {w_tns, w_tsec});
               pend_i <= i_done ? 2'b00 : (pend_i | {w_ins, w_isec});
            end
         end

         always_ff @(posedge core_clk)
         begin
            if (!rst_n)
            begin
               tgt_sec[ch] <= RESET_ZERO;
               tgt_ns[ch]  <= '0;
               int_sec[ch] <= RESET_ZERO;
               int_ns[ch]  <= '0;
               flag        <= 1'b0;
               snap_sec[ch] <= RESET_ZERO;
               snap_ns[ch]  <= '0;
            end
            else
            begin
               if (i_done)
               begin
                  int_sec[ch] <= w_isec ? reg_wdata : pend_isec;
                  int_ns[ch]  <= w_ins ? reg_wdata[29:0] : pend_ins;
               end
               // A software target committed now overrides this cycle's reload or add.
               if (t_done)
               begin
                  tgt_sec[ch] <= w_tsec ? reg_wdata : pend_tsec;
                  tgt_ns[ch]  <= w_tns ? reg_wdata[29:0] : pend_tns;
               end
               else if (hit && reload_select[ch])
               begin
                  tgt_sec[ch] <= int_sec[ch];
                  tgt_ns[ch]  <= int_ns[ch];
               end
               else if (hit)
               begin
                  tgt_sec[ch] <= tgt_sec[ch] + int_sec[ch] + {31'd0, add_c};
                  tgt_ns[ch]  <= add_c ? 30'(add_ns - {1'b0, NS_PER_SEC})
                                       : add_ns[29:0];
               end
               // The set wins over a clear arriving in the same cycle.
               if (hit)
                  flag <= 1'b1;
               else if (status_wr && reg_wdata[ch])
                  flag <= 1'b0;
               if (do_tgt_snap)
               begin
                  snap_sec[ch] <= tgt_sec[ch];
                  snap_ns[ch]  <= tgt_ns[ch];
               end
            end
         end

         assign event_flag[ch] = flag;
      end
   endgenerate

   // The summary is combinational from the flag and enable registers, so it
   // changes in the same cycle as either of them, with no delay of its own.
   assign time_event_flags   = event_flag;
   assign time_summary_event = |(event_flag & event_enable);

   ////////////////////////////////////////////////////////////////////////////
   // Read data, one cycle after the read strobe.

   // Channel target reads return the last target snapshot, never the live target,
   // so the two halves read back always belong together.
   logic [31:0] next_rdata;

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      unique case (reg_addr)
         ADDR_COMMAND:      next_rdata = {26'd0, 1'b0, temp_active, 4'd0};
         ADDR_SECONDS:      next_rdata = time_seconds_reg;
         ADDR_NANOSECONDS:  next_rdata = {2'b00, time_nanoseconds_reg};
         ADDR_SUBNANO:      next_rdata = time_subnano_reg;
         ADDR_RATE_TRIM:    next_rdata = rate_trim_reg;
         ADDR_STEP_AMOUNT:  next_rdata = step_amount_reg;
         ADDR_TEMP_TRIM:    next_rdata = temp_trim_reg;
         ADDR_TEMP_CYCLES:  next_rdata = temp_cycles_reg;
         ADDR_GENERAL_CFG:  next_rdata = 32'(reload_select);
         ADDR_EVENT_STATUS: next_rdata = 32'(event_flag);
         ADDR_EVENT_ENABLE: next_rdata = 32'(event_enable);
         default:
         begin
            for (int i = 0; i < CHANNELS; i++)
            begin
               if (reg_addr[4:2] == 3'(5'(ADDR_CH_BASE + 5'(i * CH_STRIDE)) >> 2))
               begin
                  unique case (reg_addr[1:0])
                     CH_TGT_SEC: next_rdata = snap_sec[i];
                     CH_TGT_NS:  next_rdata = {2'b00, snap_ns[i]};
                     CH_INT_SEC: next_rdata = int_sec[i];
                     CH_INT_NS:  next_rdata = {2'b00, int_ns[i]};
                  endcase
               end
            end
         end
      endcase
   end

   // Read data fall back to zero after one cycle, so a stale word is never taken twice.
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         reg_rdata <= RESET_ZERO;
      else if (reg_read)
         reg_rdata <= next_rdata;
      else
         reg_rdata <= RESET_ZERO;
   end
endmodule

// ---- sim/ptc_time_clock_asserts.sv ----
`timescale 1ns/1ps
module ptc_time_clock_asserts
   import ptc_pkg::*;
#(
   parameter int CHANNELS = 2
)
(
   // Clock and reset.
   input wire logic                core_clk,
   input wire logic                rst_n,
   // Register port.
   input wire logic [4:0]          reg_addr,
   input wire logic [31:0]         reg_wdata,
   input wire logic                reg_write,
   input wire logic                reg_read,
   input wire logic [31:0]         reg_rdata,
   // Time and events.
   input wire logic [31:0]         time_seconds,
   input wire logic [29:0]         time_nanoseconds,
   input wire logic [CHANNELS-1:0] time_event_flags,
   input wire logic                time_summary_event
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////
   // A software write may move the time anywhere, so the free-running checks skip it.
   a_ns_step_size:
   assert property ($past(rst_n) && !$past(reg_write) && time_nanoseconds >= $past(time_nanoseconds)
      |-> (time_nanoseconds - $past(time_nanoseconds)) inside {30'd9, 30'd10, 30'd11})
      else $error("bad nanosecond increment");
   a_wrap_bumps_sec:
   assert property ($past(rst_n) && !$past(reg_write) && time_nanoseconds < $past(time_nanoseconds)
      |-> time_seconds == $past(time_seconds) + 32'd1 &&
      (time_nanoseconds + NS_PER_SEC - $past(time_nanoseconds)) inside {30'd9, 30'd10, 30'd11})
      else $error("bad wrap");
   a_sec_hold_nowrap:
   assert property ($past(rst_n) && !$past(reg_write) && time_nanoseconds >= $past(time_nanoseconds)
      |-> $stable(time_seconds)) else $error("seconds moved without wrap");
   a_ns_below_limit:
   assert property (time_nanoseconds < NS_PER_SEC) else $error("nanoseconds out of range");
   a_sec_step_keeps:
   assert property ($past(rst_n) && $past(reg_write) && $past(reg_addr) == ADDR_COMMAND &&
      $past(reg_wdata) == 32'h0000_0004
      |-> (time_nanoseconds - $past(time_nanoseconds)) inside {30'd9, 30'd10, 30'd11} ||
      (time_nanoseconds + NS_PER_SEC - $past(time_nanoseconds)) inside {30'd9, 30'd10, 30'd11})
      else $error("seconds step touched nanoseconds");
   a_flag_sticky:
   assert property ($past(rst_n) && !($past(reg_write) && $past(reg_addr) == ADDR_EVENT_STATUS)
      |-> (time_event_flags & $past(time_event_flags)) == $past(time_event_flags))
      else $error("flag dropped without clear");
   a_summary_flag:
   assert property (time_summary_event |-> time_event_flags != '0)
      else $error("summary without flag");
   a_status_read:
   assert property ($past(rst_n) && $past(reg_read) && $past(reg_addr) == ADDR_EVENT_STATUS
      |-> reg_rdata[CHANNELS-1:0] == $past(time_event_flags)) else $error("status read wrong");
   c_wrap: cover property (time_nanoseconds < $past(time_nanoseconds));
   c_flag: cover property ($rose(time_event_flags[0]));
   c_summary: cover property ($rose(time_summary_event));
endmodule
bind ptc_time_clock ptc_time_clock_asserts #(.CHANNELS(CHANNELS)) i_chk (.core_clk(core_clk),
   .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
   .reg_read(reg_read), .reg_rdata(reg_rdata), .time_seconds(time_seconds),
   .time_nanoseconds(time_nanoseconds), .time_event_flags(time_event_flags),
   .time_summary_event(time_summary_event));

// ---- sim/ptp_time_clock_and_events_tb.sv ----
`timescale 1ns/1ps
module ptp_time_clock_and_events_tb;
   import ptc_pkg::*;
   localparam logic [4:0] CH_B = ADDR_CH_BASE + 5'(CH_STRIDE);
   logic        core_clk;
   logic        rst_n;
   logic [4:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_write;
   logic        reg_read;
   logic [31:0] reg_rdata;
   logic [31:0] time_seconds;
   logic [29:0] time_nanoseconds;
   logic [1:0]  time_event_flags;
   logic        time_summary_event;
   int          n_fail;
   int          compares;
   ptc_time_clock #(.CHANNELS(2)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .time_seconds(time_seconds), .time_nanoseconds(time_nanoseconds),
      .time_event_flags(time_event_flags), .time_summary_event(time_summary_event));
   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   ////////////////////////////////////////////////////////////
   task automatic err(input string m);
      n_fail++;
      $display("[ERR] %0t %s", $time, m);
   endtask
   function automatic bit ok(input bit c);
      compares++;
      return c;
   endfunction
   task automatic end_sim();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_write <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_write <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [4:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_read <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task automatic cmd(input int b);
      wr(ADDR_COMMAND, 32'h0000_0001 << b);
   endtask
   task automatic load(input logic [31:0] s, input logic [31:0] n, input logic [31:0] f);
      wr(ADDR_SECONDS, s);
      wr(ADDR_NANOSECONDS, n);
      wr(ADDR_SUBNANO, f);
      cmd(CMD_LOAD);
   endtask
   task automatic wait_flag(input int b);
      for (int k = 0; k < 1000 && time_event_flags[b] !== 1'b1; k++)
      begin
         @(posedge core_clk);
         #1;
      end
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_load_snap();
      logic [31:0] d;
      load(32'd5, 32'd1000, 32'h1234_5678);
      if (!ok(time_seconds === 32'd5 && time_nanoseconds === 30'd1000)) err("load");
      cmd(CMD_SNAPSHOT);
      rd(ADDR_NANOSECONDS, d);
      if (!ok(d === 32'd1010)) err("snapshot ns");
      rd(ADDR_SUBNANO, d);
      if (!ok(d === 32'h1234_5678)) err("snapshot subns");
      rd(ADDR_SECONDS, d);
      if (!ok(d === 32'd5)) err("snapshot sec");
      rd(5'h1F, d);
      if (!ok(d === 32'h0000_0000)) err("unmapped read");
      load(32'd7, 32'(NS_PER_SEC - 30'd25), 32'd0);
      repeat (3) @(posedge core_clk);
      #1;
      if (!ok(time_seconds === 32'd8 && time_nanoseconds === 30'd5)) err("wrap");
   endtask
   task automatic t_trim();
      for (int i = 0; i < 2; i++)
      begin
         wr(ADDR_RATE_TRIM, {i[0], 1'b0, 30'd1});
         load(32'd0, 32'd0, 32'hFFFF_FFFE);
         repeat (4) @(posedge core_clk);
         #1;
         if (!ok(time_nanoseconds === (i ? 30'd41 : 30'd39))) err("trim");
      end
      wr(ADDR_RATE_TRIM, 32'h0000_0000);
   endtask
   task automatic t_steps();
      for (int i = 0; i < 2; i++)
      begin
         wr(ADDR_STEP_AMOUNT, {i[0], 1'b0, 30'd7});
         load(32'd100, 32'(NS_PER_SEC - 30'd20), 32'd0);
         cmd(CMD_STEP_SEC);
         if (!ok(time_seconds === (i ? 32'd108 : 32'd94))) err("sec step");
         if (!ok(time_nanoseconds === 30'd0)) err("sec step ns");
      end
      wr(ADDR_STEP_AMOUNT, 32'd0);
      load(32'd9, 32'd100, 32'd0);
      cmd(CMD_STEP_NS);
      if (!ok(time_nanoseconds === 30'd110)) err("ns step pause");
      wr(ADDR_STEP_AMOUNT, 32'd999_999_995);
      cmd(CMD_STEP_NS);
      if (!ok(time_seconds === 32'd10 && time_nanoseconds === 30'd135)) err("ns step");
   endtask
   task automatic t_temp();
      logic [31:0] d;
      wr(ADDR_TEMP_TRIM, {2'b10, 30'h3FFF_FFFF});
      wr(ADDR_TEMP_CYCLES, 32'd8);
      load(32'd0, 32'd0, 32'd0);
      cmd(CMD_TEMP_RATE);
      rd(ADDR_COMMAND, d);
      if (!ok(d[CMD_TEMP_RATE] === 1'b1)) err("temp not active");
      repeat (10) @(posedge core_clk);
      rd(ADDR_COMMAND, d);
      if (!ok(d[CMD_TEMP_RATE] === 1'b0)) err("temp not cleared");
      // Sixteen ticks since the load, eight of them fast, carry the accumulator once.
      if (!ok(time_nanoseconds === 30'd161)) err("temp rate");
   endtask
   task automatic t_compare();
      logic [31:0] d;
      load(32'd3, 32'd0, 32'd0);
      wr(ADDR_GENERAL_CFG, 32'h0000_0000);
      wr(ADDR_CH_BASE + CH_TGT_SEC, 32'd3);
      wr(ADDR_CH_BASE + CH_TGT_NS, 32'd1000);
      wr(CH_B + CH_TGT_NS, 32'd5000);
      wr(CH_B + CH_TGT_SEC, 32'd3);
      wr(ADDR_CH_BASE + CH_INT_NS, 32'd200);
      wr(ADDR_CH_BASE + CH_INT_SEC, 32'd0);
      wr(CH_B + CH_INT_SEC, 32'd3);
      wr(CH_B + CH_INT_NS, 32'd9000);
      wr(ADDR_EVENT_ENABLE, 32'h0000_0000);
      wr(ADDR_EVENT_STATUS, 32'h0000_0003);
      if (!ok(time_event_flags === 2'b00)) err("flags early");
      wait_flag(0);
      if (!ok(time_event_flags === 2'b01 && time_nanoseconds === 30'd1010)) err("hit A");
      if (!ok(time_summary_event === 1'b0)) err("summary unmasked");
      rd(ADDR_EVENT_STATUS, d);
      if (!ok(d === 32'h0000_0001)) err("status read");
      rd(ADDR_CH_BASE + CH_INT_NS, d);
      if (!ok(d === 32'd200)) err("interval read");
      wr(ADDR_EVENT_ENABLE, 32'h0000_0001);
      if (!ok(time_summary_event === 1'b1)) err("summary");
      wr(ADDR_EVENT_STATUS, 32'h0000_0001);
      if (!ok(time_event_flags[0] === 1'b0)) err("clear A");
      wait_flag(0);
      if (!ok(time_nanoseconds === 30'd1210)) err("add A");
      wr(ADDR_GENERAL_CFG, 32'h0000_0002);
      wait_flag(1);
      if (!ok(time_nanoseconds === 30'd5010)) err("hit B");
      cmd(CMD_TGT_SNAP);
      rd(CH_B + CH_TGT_NS, d);
      if (!ok(d === 32'd9000)) err("reload B ns");
      rd(CH_B + CH_TGT_SEC, d);
      if (!ok(d === 32'd3)) err("reload B sec");
      wr(ADDR_EVENT_STATUS, 32'h0000_0002);
      if (!ok(time_event_flags[1] === 1'b0)) err("clear B");
      load(32'd4, 32'd0, 32'd0);
      repeat (2) @(posedge core_clk);
      #1;
      if (!ok(time_event_flags[1] === 1'b1)) err("load event");
   endtask
   ////////////////////////////////////////////////////////////
   initial
   begin
      #100_000;
      err("timeout");
      end_sim();
   end
   initial
   begin
      rst_n     = 1'b0;
      reg_addr  = 5'h00;
      reg_wdata = 32'h0000_0000;
      reg_write = 1'b0;
      reg_read  = 1'b0;
      n_fail    = 0;
      compares  = 0;
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      #1;
      if (!ok(time_seconds === 32'd0 && time_event_flags === 2'b00)) err("reset values");
      t_load_snap();
      t_trim();
      t_steps();
      t_temp();
      t_compare();
      end_sim();
   end
endmodule
